/* hw/general_purpose_io_port.sv */
// Purpose : Eight-pin general-purpose port plus parallel pin I/O registers
// Assumes : Peripheral bus with one-cycle select, word addresses
// Notes   : Shared pin function is caught while reset is held
//
// Operation
// - Eight separately configurable pins map pin 0 to bit 0 up to pin 7 at bit 7.
// - Direction sits at 0x3400 and level at 0x3401, both read and written over the bus.
// - Boot select low during reset gives port bits 3 and 5, high gives serial-2 clock/sync.
// - The shared pin function is fixed at reset release until the next reset.
// - Direction 0 is input and 1 is output, and all directions reset to input.
// - With direction 0 the level bit reads the sampled pin level.
// - With direction 1 the level bit sets the driven pin level.
// - After reset the level register reflects the pin levels, not a constant.
// - Each bus and host pin may serve as parallel I/O when the bus is not in full mode.
// - Three enable registers switch the output driver of each parallel pin.
// - Three direction registers choose whether a level bit reads back the latch or the pin.
// - Three level registers hold the driven or sampled parallel pin values.
// - Parallel enables never override full bus mode, which keeps the bus functions.

`timescale 1ns/10ps

module general_purpose_io_port #(
  parameter int unsigned PAR_NPINS = gpio_pkg::PAR_PINS  // Parallel pin count
) (
  input  wire logic                        mclk,                // 40 MHz clock
  input  wire logic                        rst,                 // Sync reset, high
  input  wire logic                        per_sel,             // Bus access strobe
  input  wire logic                        per_we,              // 1 write, 0 read
  input  wire logic [gpio_pkg::ADDR_W-1:0] per_addr,            // Word address
  input  wire logic [gpio_pkg::REG_W-1:0]  per_wdata,           // Write data
  output logic      [gpio_pkg::REG_W-1:0]  per_rdata,           // Read data
  output logic                             per_ack,             // Access done
  input  wire logic [gpio_pkg::PORT_W-1:0] port_pin_i,          // Port pin levels
  output logic      [gpio_pkg::PORT_W-1:0] port_pin_o,          // Port pin drive
  output logic      [gpio_pkg::PORT_W-1:0] port_pin_oe,         // Port pin enable
  input  wire logic                        serial2_tx_clock_o,  // Serial clock out
  input  wire logic                        serial2_tx_clock_oe, // Serial clock enable
  output logic                             serial2_tx_clock_i,  // Serial clock in
  input  wire logic                        serial2_tx_fsync_o,  // Frame sync out
  input  wire logic                        serial2_tx_fsync_oe, // Frame sync enable
  output logic                             serial2_tx_fsync_i,  // Frame sync in
  output logic                             serial2_pins_owned,  // Shared pins to serial
  input  wire logic                        full_bus_mode,       // Bus mux mode full
  input  wire logic [PAR_NPINS-1:0]        par_pin_i,           // Parallel pin levels
  output logic      [PAR_NPINS-1:0]        par_pin_o,           // Parallel drive
  output logic      [PAR_NPINS-1:0]        par_pin_oe           // Parallel enable
);
  import gpio_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (PAR_NPINS < 1 || PAR_NPINS > PAR_MAXW) begin : g_bad_par
    $error("general_purpose_io_port: PAR_NPINS out of range");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [PORT_W-1:0] dir;    // Direction bits
    logic [PORT_W-1:0] out;    // Output latch
    logic [PORT_W-1:0] s1;     // Pin sync, first flop
    logic [PORT_W-1:0] s2;     // Pin sync, second flop
    shared_fn_e        fn;     // Shared pin function
    logic [REG_W-1:0]  rdata;  // Registered read data
    logic              ack;    // Access acknowledge
  } port_s;

  port_s             st_q;
  port_s             st_d;
  logic [PORT_W-1:0] level_view;
  logic              serial_sel;

  pbank_if bank_bus ();

  // ----------------------------------------------------------------------
  // Level register view
  // ----------------------------------------------------------------------
  // Outputs read back the latch, inputs read the synchronised pin
  assign level_view = (st_q.dir & st_q.out) | (~st_q.dir & st_q.s2);
  assign serial_sel = (st_q.fn == FN_SERIAL);

  // Path to the parallel bank
  assign bank_bus.wr_en = per_sel && per_we;
  assign bank_bus.addr  = per_addr;
  assign bank_bus.wdata = per_wdata;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.s1    = port_pin_i;
    st_d.s2    = st_q.s1;
    st_d.ack   = per_sel;
    st_d.rdata = st_q.rdata;

    // Register read, unmapped reads zero
    if (per_sel && !per_we) begin
      if (per_addr == PORT_DIRECTION_OFS) begin
        st_d.rdata = {8'h00, st_q.dir};
      end else if (per_addr == PORT_LEVEL_OFS) begin
        st_d.rdata = {8'h00, level_view};
      end else if (bank_bus.hit) begin
        st_d.rdata = bank_bus.rdata;
      end else begin
        st_d.rdata = READ_ZERO;
      end
    end

    // Register write, upper byte dropped
    if (per_sel && per_we) begin
      if (per_addr == PORT_DIRECTION_OFS) begin
        st_d.dir = per_wdata[PORT_W-1:0];
      end else if (per_addr == PORT_LEVEL_OFS) begin
        st_d.out = per_wdata[PORT_W-1:0];
      end
    end

    // Reset; shared function follows boot select while held
    if (rst) begin
      st_d.dir   = PORT_DIRECTION_RST;
      st_d.out   = PORT_OUT_RST;
      st_d.rdata = READ_ZERO;
      st_d.ack   = 1'b0;
      st_d.fn    = st_q.s2[BOOT_SELECT_BIT] ? FN_SERIAL : FN_PORT;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------------
  // Port pin drive
  // ----------------------------------------------------------------------
  always_comb begin
    port_pin_o  = st_q.out;
    port_pin_oe = st_q.dir;
    if (serial_sel) begin
      port_pin_o[SHARED_A_BIT]  = serial2_tx_clock_o;
      port_pin_oe[SHARED_A_BIT] = serial2_tx_clock_oe;
      port_pin_o[SHARED_B_BIT]  = serial2_tx_fsync_o;
      port_pin_oe[SHARED_B_BIT] = serial2_tx_fsync_oe;
    end
    // Released during reset so the boot level reaches the sync clean
    if (rst) begin
      port_pin_oe = '0;
    end
  end

  // Serial side sees synchronised shared pins only in serial function
  assign serial2_tx_clock_i = serial_sel & st_q.s2[SHARED_A_BIT];
  assign serial2_tx_fsync_i = serial_sel & st_q.s2[SHARED_B_BIT];
  assign serial2_pins_owned = serial_sel;

  // ----------------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------------
  assign per_rdata = st_q.rdata;
  assign per_ack   = st_q.ack;

  // ----------------------------------------------------------------------
  // Parallel pin bank
  // ----------------------------------------------------------------------
  par_pin_bank #(
    .NPINS         (PAR_NPINS)
  ) u_bank (
    .mclk          (mclk),
    .rst           (rst),
    .bus           (bank_bus.bank),
    .full_bus_mode (full_bus_mode),
    .pin_i         (par_pin_i),
    .pin_o         (par_pin_o),
    .pin_oe        (par_pin_oe)
  );

endmodule : general_purpose_io_port

/* hw/gpio_pkg.sv */
// Purpose : Shared constants and types for the general-purpose I/O port
// Assumes : 16-bit peripheral bus, word addressed
// Notes   : Offsets are word addresses on the peripheral bus

package gpio_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned REG_W    = 16;
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned PORT_W   = 8;
  localparam int unsigned PAR_SETS = 3;
  localparam int unsigned PAR_PINS = 46;
  localparam int unsigned PAR_MAXW = PAR_SETS * REG_W;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PORT_DIRECTION_OFS = 16'h3400;
  localparam logic [ADDR_W-1:0] PORT_LEVEL_OFS     = 16'h3401;
  localparam logic [ADDR_W-1:0] PAR_BASE_OFS       = 16'h4400;
  localparam logic [ADDR_W-1:0] PAR_SET_STRIDE     = 16'h0003;
  localparam logic [ADDR_W-1:0] PAR_SPAN           = 16'h0009;

  // Register kind inside one parallel set
  localparam logic [1:0] PAR_KIND_ENABLE    = 2'h0;
  localparam logic [1:0] PAR_KIND_DIRECTION = 2'h1;
  localparam logic [1:0] PAR_KIND_LEVEL     = 2'h2;

  // ----------------------------------------------------------------------
  // Reset values and bit positions
  // ----------------------------------------------------------------------
  localparam logic [PORT_W-1:0] PORT_DIRECTION_RST = 8'h00;
  localparam logic [PORT_W-1:0] PORT_OUT_RST       = 8'h00;
  localparam logic [REG_W-1:0]  PAR_REG_RST        = 16'h0000;
  localparam logic [REG_W-1:0]  READ_ZERO          = 16'h0000;
  localparam int unsigned       SHARED_A_BIT       = 3;
  localparam int unsigned       SHARED_B_BIT       = 5;
  localparam int unsigned       BOOT_SELECT_BIT    = 7;

  // Function of the two shared pins
  typedef enum logic [1:0] {
    FN_PORT   = 2'b01,
    FN_SERIAL = 2'b10
  } shared_fn_e;

  // Decode of a parallel register address: {hit, set, kind}
  typedef struct packed {
    logic       hit;
    logic [1:0] set;
    logic [1:0] kind;
  } par_dec_s;

  // Parallel register address decode
  function automatic par_dec_s par_decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] offs;
    par_dec_s          d;
    offs   = addr - PAR_BASE_OFS;
    d.hit  = (addr >= PAR_BASE_OFS) && (offs < PAR_SPAN);
    d.set  = 2'(offs / PAR_SET_STRIDE);
    d.kind = 2'(offs % PAR_SET_STRIDE);
    return d;
  endfunction : par_decode

endpackage : gpio_pkg

/* hw/par_pin_bank.sv */
// Purpose : Enable, direction and level registers of the parallel pins
// Assumes : Pins synchronised here by two flops
// Notes   : Pins are released to the bus when full bus mode is selected

`timescale 1ns/10ps

module par_pin_bank #(
  parameter int unsigned NPINS = gpio_pkg::PAR_PINS  // Parallel pin count
) (
  input  wire logic             mclk,          // System clock
  input  wire logic             rst,           // Sync reset, high
  pbank_if.bank                 bus,           // Register path
  input  wire logic             full_bus_mode, // Pins belong to the bus
  input  wire logic [NPINS-1:0] pin_i,         // Pin levels
  output logic      [NPINS-1:0] pin_o,         // Pin drive values
  output logic      [NPINS-1:0] pin_oe         // Pin drive enables
);
  import gpio_pkg::*;

  if (NPINS < 1 || NPINS > PAR_MAXW) begin : g_bad_npins
    $error("par_pin_bank: NPINS out of range");
  end

  typedef struct packed {
    logic [PAR_SETS-1:0][REG_W-1:0] en;
    logic [PAR_SETS-1:0][REG_W-1:0] dir;
    logic [PAR_SETS-1:0][REG_W-1:0] lvl;
    logic [PAR_MAXW-1:0]            s1;
    logic [PAR_MAXW-1:0]            s2;
  } bank_s;

  bank_s               st_q;
  bank_s               st_d;
  par_dec_s            dec;
  logic [PAR_MAXW-1:0] pad;
  logic [PAR_MAXW-1:0] en_flat;
  logic [PAR_MAXW-1:0] lvl_flat;

  // Bits of a set that map to real pins
  function automatic logic [REG_W-1:0] set_mask(input logic [1:0] set);
    logic [REG_W-1:0] m;
    m = '0;
    for (int i = 0; i < REG_W; i++) begin
      m[i] = (int'(set) * REG_W + i) < NPINS;
    end
    return m;
  endfunction : set_mask

  // ----------------------------------------------------------------------
  // Next state and register read
  // ----------------------------------------------------------------------
  always_comb begin
    logic [REG_W-1:0] pinw;
    pinw = '0;
    dec  = par_decode(bus.addr);
    pad  = '0;
    pad[NPINS-1:0] = pin_i;
    st_d    = st_q;
    st_d.s1 = pad;
    st_d.s2 = st_q.s1;
    bus.hit = dec.hit && (dec.set < 2'(PAR_SETS));
    bus.rdata = READ_ZERO;
    if (bus.hit) begin
      pinw = st_q.s2[dec.set*REG_W +: REG_W];
      unique case (dec.kind)
        PAR_KIND_ENABLE:    bus.rdata = st_q.en[dec.set];
        PAR_KIND_DIRECTION: bus.rdata = st_q.dir[dec.set];
        default:            bus.rdata = (st_q.dir[dec.set] & st_q.lvl[dec.set])
                                      | (~st_q.dir[dec.set] & pinw);
      endcase
      bus.rdata = bus.rdata & set_mask(dec.set);
    end
    if (bus.wr_en && bus.hit) begin
      unique case (dec.kind)
        PAR_KIND_ENABLE:    st_d.en[dec.set]  = bus.wdata & set_mask(dec.set);
        PAR_KIND_DIRECTION: st_d.dir[dec.set] = bus.wdata & set_mask(dec.set);
        default:            st_d.lvl[dec.set] = bus.wdata & set_mask(dec.set);
      endcase
    end
    if (rst) begin
      for (int s = 0; s < PAR_SETS; s++) begin
        st_d.en[s]  = PAR_REG_RST;
        st_d.dir[s] = PAR_REG_RST;
        st_d.lvl[s] = PAR_REG_RST;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------------
  // Pin drive; bus mode always keeps the pins
  // ----------------------------------------------------------------------
  assign en_flat  = st_q.en;
  assign lvl_flat = st_q.lvl;
  assign pin_o    = lvl_flat[NPINS-1:0];
  assign pin_oe   = en_flat[NPINS-1:0] & {NPINS{~(full_bus_mode | rst)}};

endmodule : par_pin_bank

/* hw/pbank_if.sv */
// Purpose : Register path between the port top and the parallel pin bank
// Assumes : One clock, write strobe qualified by the top
// Notes   : Read data is combinational from the bank

`timescale 1ns/10ps

interface pbank_if;
  logic        wr_en;  // Write strobe
  logic [15:0] addr;   // Word address
  logic [15:0] wdata;  // Write data
  logic        hit;    // Address belongs to the bank
  logic [15:0] rdata;  // Read data of addressed register

  modport host (output wr_en, output addr, output wdata, input hit, input rdata);
  modport bank (input wr_en, input addr, input wdata, output hit, output rdata);
endinterface : pbank_if

/* sim/general_purpose_io_port_tb_top.sv */
// Purpose : Directed tests of the port registers, pins and shared function
// Assumes : Ack one cycle after each strobe cycle
// Notes   : Pins resolved by the board model
`timescale 1ns/10ps
module general_purpose_io_port_tb_top;
  logic        mclk = 1'b0, rst = 1'b1, per_sel = 1'b0, per_we = 1'b0, per_ack;
  logic [15:0] per_addr = 16'h0000, per_wdata = 16'h0000, per_rdata;
  logic [7:0]  port_pin_i, port_pin_o, port_pin_oe, port_drive = 8'h5a;
  logic        serial2_tx_clock_o = 1'b0, serial2_tx_clock_oe = 1'b0, serial2_tx_clock_i;
  logic        serial2_tx_fsync_o = 1'b0, serial2_tx_fsync_oe = 1'b0, serial2_tx_fsync_i;
  logic        serial2_pins_owned, full_bus_mode = 1'b0;
  logic [45:0] par_pin_i, par_pin_o, par_pin_oe, par_drive = '0;
  int          errors = 0, n_compared = 0;

  general_purpose_io_port u_dut (.*);
  pin_board_model u_board (.*);

  // Clock, 25 ns period
  always #12.5 mclk = ~mclk;

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic we, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    per_sel   <= 1'b1;
    per_we    <= we;
    per_addr  <= a;
    per_wdata <= d;
    @(posedge mclk);
    per_sel <= 1'b0;
    #1;
    check(per_ack, 1'b1);
  endtask : xfer

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    xfer(1'b0, a, 16'h0000);
    check(per_rdata, exp);
  endtask : rd

  task automatic do_reset(input logic boot);
    @(posedge mclk);
    port_drive[7] <= boot;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_state();
    #1;
    check(serial2_pins_owned, 1'b0);
    rd(16'h3400, 16'h0000);
    rd(16'h3401, 16'h005a);
    $display("reset state done");
  endtask : t_reset_state

  task automatic t_output_drive();
    xfer(1'b1, 16'h3400, 16'hffff);
    check(port_pin_oe, 8'hff);
    xfer(1'b1, 16'h3401, 16'ha5c3);
    check(port_pin_o, 8'hc3);
    rd(16'h3400, 16'h00ff);
    rd(16'h3401, 16'h00c3);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 16'h3400, 16'h0001 << i);
      check(port_pin_oe, 8'h01 << i);
    end
    $display("output drive done");
  endtask : t_output_drive

  task automatic t_input_sample();
    xfer(1'b1, 16'h3400, 16'h000f);
    @(posedge mclk);
    port_drive <= 8'h3c;
    repeat (3) @(posedge mclk);
    rd(16'h3401, 16'h0033);
    rd(16'h1234, 16'h0000);
    $display("input sample done");
  endtask : t_input_sample

  task automatic t_serial_boot();
    do_reset(1'b1);
    serial2_tx_clock_o  <= 1'b1;
    serial2_tx_clock_oe <= 1'b1;
    serial2_tx_fsync_oe <= 1'b1;
    port_drive[7]       <= 1'b0;
    #1;
    check(serial2_pins_owned, 1'b1);
    repeat (4) @(posedge mclk);
    #1;
    check(port_pin_oe & 8'h28, 8'h28);
    check(serial2_tx_clock_i, 1'b1);
    check(serial2_tx_fsync_i, 1'b0);
    check(serial2_pins_owned, 1'b1);
    do_reset(1'b0);
    #1;
    check(serial2_pins_owned, 1'b0);
    $display("serial boot done");
  endtask : t_serial_boot

  task automatic t_parallel();
    xfer(1'b1, 16'h4401, 16'hffff);
    xfer(1'b1, 16'h4400, 16'hffff);
    xfer(1'b1, 16'h4402, 16'h1234);
    check(par_pin_oe[15:0], 16'hffff);
    check(par_pin_o[15:0], 16'h1234);
    @(posedge mclk);
    full_bus_mode <= 1'b1;
    par_drive     <= {14'h2a5a, 16'h0000, 16'hbeef};
    @(posedge mclk);
    #1;
    check(par_pin_oe, 46'h0);
    @(posedge mclk);
    full_bus_mode <= 1'b0;
    xfer(1'b1, 16'h4400, 16'h0000);
    xfer(1'b1, 16'h4401, 16'h00ff);
    xfer(1'b1, 16'h4406, 16'h0000);
    xfer(1'b1, 16'h4407, 16'h0000);
    rd(16'h4402, 16'hbe34);
    rd(16'h4401, 16'h00ff);
    rd(16'h4408, 16'h2a5a);
    $display("parallel pins done");
  endtask : t_parallel

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset_state();
    t_output_drive();
    t_input_sample();
    t_serial_boot();
    t_parallel();
    summarize();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (2000) @(posedge mclk);
    errors++;
    $display("watchdog expired");
    summarize();
  end
endmodule : general_purpose_io_port_tb_top

/* sim/gpio_port_monitor.sv */
// Purpose : Concurrent checks on the pins and bus answer of the I/O port
// Assumes : One clock, sync reset high
// Notes   : Bits 3 and 5 are masked where the serial function may own them
`timescale 1ns/10ps
module gpio_port_monitor #(
  parameter int unsigned PAR_NPINS = 46  // Parallel pin count
) (
  input wire logic                 mclk,                // Clock
  input wire logic                 rst,                 // Sync reset
  input wire logic                 per_sel,             // Bus strobe
  input wire logic                 per_we,              // Write select
  input wire logic [15:0]          per_addr,            // Address
  input wire logic [15:0]          per_wdata,           // Write data
  input wire logic [15:0]          per_rdata,           // Read data
  input wire logic                 per_ack,             // Access done
  input wire logic [7:0]           port_pin_i,          // Pin levels
  input wire logic [7:0]           port_pin_o,          // Pin drive
  input wire logic [7:0]           port_pin_oe,         // Pin enable
  input wire logic                 serial2_tx_clock_o,  // Serial clock out
  input wire logic                 serial2_tx_clock_oe, // Serial clock enable
  input wire logic                 serial2_tx_clock_i,  // Serial clock in
  input wire logic                 serial2_tx_fsync_o,  // Sync out
  input wire logic                 serial2_tx_fsync_oe, // Sync enable
  input wire logic                 serial2_tx_fsync_i,  // Sync in
  input wire logic                 serial2_pins_owned,  // Serial owns pins
  input wire logic                 full_bus_mode,       // Bus mode
  input wire logic [PAR_NPINS-1:0] par_pin_i,           // Parallel levels
  input wire logic [PAR_NPINS-1:0] par_pin_o,           // Parallel drive
  input wire logic [PAR_NPINS-1:0] par_pin_oe           // Parallel enable
);
  localparam logic [7:0] PM = 8'hd7;  // Bits never shared
  logic [15:0] wd_q;
  logic        rd_port_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Delayed write data and port read marker
  always_ff @(posedge mclk) begin
    wd_q      <= per_wdata;
    rd_port_q <= per_sel && !per_we && (per_addr[15:1] == 15'h1a00);
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  ack_after_sel_a: assert property (per_sel |=> per_ack)
    else $error("no ack after access");
  ack_needs_sel_a: assert property (per_ack |-> $past(per_sel))
    else $error("ack without access");
  dir_reset_a: assert property ($fell(rst) |-> (port_pin_oe & PM) == 8'h00)
    else $error("direction not input after reset");
  dir_write_a: assert property (per_sel && per_we && per_addr == 16'h3400
    |=> ((port_pin_oe ^ wd_q[7:0]) & PM) == 8'h00) else $error("direction write lost");
  level_drive_a: assert property (per_sel && per_we && per_addr == 16'h3401
    |=> ((port_pin_o ^ wd_q[7:0]) & PM) == 8'h00) else $error("level write lost");
  high_zero_a: assert property (per_ack && rd_port_q |-> per_rdata[15:8] == 8'h00)
    else $error("upper bits not zero");
  fn_stable_a: assert property (!$past(rst) |-> $stable(serial2_pins_owned))
    else $error("shared function changed");
  serial_mux_a: assert property (serial2_pins_owned |-> port_pin_o[3] == serial2_tx_clock_o
    && port_pin_oe[3] == serial2_tx_clock_oe && port_pin_o[5] == serial2_tx_fsync_o
    && port_pin_oe[5] == serial2_tx_fsync_oe) else $error("serial pins not routed");
  serial_idle_a: assert property (!serial2_pins_owned
    |-> !serial2_tx_clock_i && !serial2_tx_fsync_i) else $error("serial input leaks");
  bus_mode_a: assert property (full_bus_mode |-> par_pin_oe == '0)
    else $error("parallel drive in bus mode");

  // Main scenarios reached
  cover property (per_sel && per_we ##1 per_ack);
  cover property (serial2_pins_owned && serial2_tx_clock_oe);
  cover property (full_bus_mode && par_pin_o != '0);
endmodule : gpio_port_monitor

bind general_purpose_io_port gpio_port_monitor #(.PAR_NPINS(PAR_NPINS)) u_mon (.*);

/* sim/pin_board_model.sv */
// Purpose : Board levels seen on the port and parallel pins
// Assumes : Board drives only pins the device releases
// Notes   : No pull resistors; board level is always driven
`timescale 1ns/10ps
module pin_board_model #(
  parameter int unsigned NP = 46  // Parallel pin count
) (
  input  wire logic [7:0]    port_pin_o,  // Device drive
  input  wire logic [7:0]    port_pin_oe, // Device enable
  input  wire logic [7:0]    port_drive,  // Board level
  output logic      [7:0]    port_pin_i,  // Pin level
  input  wire logic [NP-1:0] par_pin_o,   // Device drive
  input  wire logic [NP-1:0] par_pin_oe,  // Device enable
  input  wire logic [NP-1:0] par_drive,   // Board level
  output logic      [NP-1:0] par_pin_i    // Pin level
);
  // Pin level from whichever side drives it
  assign port_pin_i = (port_pin_oe & port_pin_o) | (~port_pin_oe & port_drive);
  assign par_pin_i  = (par_pin_oe & par_pin_o) | (~par_pin_oe & par_drive);
endmodule : pin_board_model
